// ---- dv/pin_model.sv ----
`timescale 1ns/10ps
module pin_model (
  // clock
  input wire logic clk,
  // pins toward the timer, idle high
  output logic cnt_pin,
  output logic trg_pin
);
  initial begin
    cnt_pin = 1'b1;
    trg_pin = 1'b1;
  end
  // one falling edge
  // levels held three clocks, above the two-clock minimum
  task automatic fall(input logic trig);
    @(posedge clk);
    if (trig) trg_pin <= 1'b0;
    else cnt_pin <= 1'b0;
    repeat (3) @(posedge clk);
    trg_pin <= 1'b1;
    cnt_pin <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
endmodule

// ---- dv/tb_timer2_capture_reload.sv ----
`timescale 1ns/10ps
module tb_timer2_capture_reload;
  import tmr2_pkg::*;
  logic clk, resetn, wr, rd, rd_d, cnt_pin, trg_pin, irq, baud;
  logic [7:0] addr, wdata, rdata;
  logic [15:0] seed, w;
  logic [8:0] exp_q[$];
  int n_mismatch, n_tests, n_baud, cyc;
  timer2_capture_reload i_timer2_capture_reload (.CLK(clk),
    .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .COUNT_PIN(cnt_pin), .TRIGGER_PIN(trg_pin),
    .IRQ(irq), .BAUD_TICK(baud));
  pin_model i_pin_model (.clk(clk), .cnt_pin(cnt_pin), .trg_pin(trg_pin));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
  endtask
  // bit 8 of a note means the value is not compared
  task automatic rd_reg(logic [7:0] a, logic [8:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    exp_q.push_back(e);
  endtask
  task automatic idle(int n);
    repeat (n) begin
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask
  // five counts from fffd: two before the wrap, the wrap that reloads, two after reload
  task automatic ovf(logic [7:0] c, logic [8:0] e, logic [7:0] s);
    logic [15:0] r, n;
    seed = lfsr(seed);
    r = {1'b0, seed[14:0]};
    n = r + 16'h0002;
    wr_reg(8'hca, r[7:0]);
    wr_reg(8'hcb, r[15:8]);
    wr_reg(8'hcc, 8'hfd);
    wr_reg(8'hcd, 8'hff);
    wr_reg(8'hc8, c);
    rd_reg(8'hc8, 9'h100);
    rd_reg(8'hcc, 9'h100);
    rd_reg(8'hcc, 9'h100);
    rd_reg(8'hc8, e);
    wr_reg(8'hc8, s);
    rd_reg(8'hcc, {1'b0, n[7:0]});
    rd_reg(8'hcd, {1'b0, n[15:8]});
    idle(3);
  endtask
  always @(posedge clk) begin
    rd_d <= rd;
    cyc++;
    if (baud === 1'b1) n_baud++;
    if (rd_d && exp_q.size() > 0) begin
      if (!exp_q[0][8]) begin
        check("rdata", {8'h00, rdata}, {8'h00, exp_q[0][7:0]});
      end
      void'(exp_q.pop_front());
    end
    if (cyc == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    {addr, wdata, wr, rd, resetn} = '0;
    {n_mismatch, n_tests, n_baud, cyc} = '0;
    seed = 16'h560e;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd_reg(8'hc8, 9'h000);
    rd_reg(8'hc9, 9'h000);
    wr_reg(8'hd1, 8'h01);
    ovf(8'h04, 9'h084, 8'h80);
    check("irq", {15'h0000, irq}, 16'h0001);
    rd_reg(8'hd0, 9'h001);
    idle(3);
    check("irq", {15'h0000, irq}, 16'h0000);
    seed = lfsr(seed);
    w = {1'b0, seed[14:0]};
    wr_reg(8'hd1, 8'h02);
    wr_reg(8'hc8, 8'h0f);
    wr_reg(8'hcc, w[7:0]);
    wr_reg(8'hcd, w[15:8]);
    idle(1);
    i_pin_model.fall(1'b1);
    rd_reg(8'hca, {1'b0, w[7:0]});
    rd_reg(8'hcb, {1'b0, w[15:8]});
    rd_reg(8'hc8, 9'h04f);
    idle(2);
    check("irq", {15'h0000, irq}, 16'h0001);
    repeat (3) i_pin_model.fall(1'b0);
    rd_reg(8'hcc, {1'b0, w[7:0] + 8'h03});
    wr_reg(8'hc8, 8'h0e);
    wr_reg(8'hcc, 8'h00);
    wr_reg(8'hcd, 8'h00);
    idle(1);
    i_pin_model.fall(1'b1);
    rd_reg(8'hcc, {1'b0, w[7:0]});
    rd_reg(8'hcd, {1'b0, w[15:8]});
    rd_reg(8'hd0, 9'h002);
    wr_reg(8'hd1, 8'h00);
    wr_reg(8'hc8, 8'h10);
    ovf(8'h15, 9'h015, 8'h00);
    check("irq", {15'h0000, irq}, 16'h0000);
    rd_reg(8'hd0, 9'h004);
    idle(3);
    check("baud", n_baud[15:0], 16'h0001);
    print_verdict();
  end
endmodule

// ---- dv/timer2_capture_reload_sva.sv ----
`timescale 1ns/10ps
module timer2_capture_reload_sva
  import tmr2_pkg::*;
#(
  parameter int unsigned CW = COUNT_W
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [DATA_W-1:0] RDATA,
  // pins and events
  input wire logic COUNT_PIN,
  input wire logic TRIGGER_PIN,
  input wire logic IRQ,
  input wire logic BAUD_TICK
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  logic [7:0] ctl_ff;
  logic [2:0] msk_ff;
  // software shadows only; hardware flags are not tracked
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctl_ff <= 8'h00;
      msk_ff <= 3'h0;
    end else if (WR && ADDR == 8'hc8) begin
      ctl_ff <= WDATA;
    end else if (WR && ADDR == 8'hd1) begin
      msk_ff <= WDATA[2:0];
    end
  end
  sequence cc_twice_s;
    RD && ADDR == 8'hcc && ctl_ff[5:1] == 5'h02 ##1 RD && ADDR == 8'hcc;
  endsequence
  sequence baud_start_s;
    ctl_ff[5:4] != 2'h0 && WR && ADDR == 8'hc8 && !WDATA[7];
  endsequence
  property ctl_keep_p;
    logic [7:0] v;
    (WR && ADDR == 8'hc8, v = WDATA) ##1 (RD && ADDR == 8'hc8)
      |=> RDATA[5:0] == v[5:0];
  endproperty
  chk_rd_idle: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data not idle");
  chk_rd_unmapped: assert property (RD && ADDR == 8'hc9 |=> !RDATA)
    else $error("unmapped read not zero");
  chk_ctl_keep: assert property (ctl_keep_p)
    else $error("control bits not kept");
  chk_timer_step: assert property (cc_twice_s |=>
    RDATA == $past(RDATA) + 8'h01 || $past(RDATA) == 8'hff)
    else $error("timer not counting each clock");
  chk_flag_baud: assert property (baud_start_s ##1
    (RD && ADDR == 8'hc8) ##3 (RD && ADDR == 8'hc8 && ctl_ff[5:4] != 2'h0)
    |=> !RDATA[7])
    else $error("overflow flag set in baud mode");
  chk_baud_only: assert property (BAUD_TICK |->
    ctl_ff[5:4] != 2'h0 || ($past(ctl_ff) & 8'h30) != 8'h00)
    else $error("baud tick outside baud mode");
  chk_irq_masked: assert property (WR && ADDR == 8'hd1 && !WDATA[2:0]
    ##1 !(WR && ADDR == 8'hd1) |=> !IRQ)
    else $error("interrupt while all masked");
  chk_irq_cause: assert property (IRQ |-> msk_ff || $past(msk_ff))
    else $error("interrupt without mask bit");
endmodule
bind timer2_capture_reload timer2_capture_reload_sva #(.CW(CW)) i_sva (
  .CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .COUNT_PIN(COUNT_PIN),
  .TRIGGER_PIN(TRIGGER_PIN), .IRQ(IRQ), .BAUD_TICK(BAUD_TICK));

// ---- shared/tmr2_pkg.sv ----
package tmr2_pkg;

  // widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned COUNT_W = 16;
  localparam int unsigned IRQ_W = 3;

  // register addresses
  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'hc8;
  localparam logic [7:0] ADDR_CAPTURE_RELOAD_LOW = 8'hca;
  localparam logic [7:0] ADDR_CAPTURE_RELOAD_HIGH = 8'hcb;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hd0;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hd1;

  // timer_control field positions
  localparam int unsigned BIT_OVERFLOW_FLAG = 7;
  localparam int unsigned BIT_EXTERNAL_TRIGGER_FLAG = 6;
  localparam int unsigned BIT_RECEIVE_BAUD_CLOCK_SELECT = 5;
  localparam int unsigned BIT_TRANSMIT_BAUD_CLOCK_SELECT = 4;
  localparam int unsigned BIT_EXTERNAL_TRIGGER_ENABLE = 3;
  localparam int unsigned BIT_RUN_CONTROL = 2;
  localparam int unsigned BIT_COUNTER_SELECT = 1;
  localparam int unsigned BIT_CAPTURE_SELECT = 0;

  // interrupt status / mask field positions
  localparam int unsigned IRQ_BIT_OVERFLOW = 0;
  localparam int unsigned IRQ_BIT_TRIGGER = 1;
  localparam int unsigned IRQ_BIT_BAUD = 2;

  // reset values
  localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] CAPTURE_RELOAD_RESET = 16'h0000;
  localparam logic [7:0] READ_DATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [2:0] IRQ_STATUS_RESET = 3'h0;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

endpackage

// ---- verilog/fall_edge_sync.sv ----
`timescale 1ns/10ps
module fall_edge_sync
  import tmr2_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // pin and event
  input wire logic pin,
  output logic fall
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_t;

  sync_t state_ff;
  sync_t nxt_state;

  // meta is read only by sync; edge logic sees sync and prev
  always_comb begin
    nxt_state.meta = pin;
    nxt_state.sync = state_ff.meta;
    nxt_state.prev = state_ff.sync;
  end

  // pins idle high, so reset to one avoids a false edge after release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= 3'h7;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign fall = state_ff.prev & ~state_ff.sync;

endmodule

// ---- verilog/irq_sticky.sv ----
`timescale 1ns/10ps
module irq_sticky
  import tmr2_pkg::*;
#(
  parameter int unsigned N = IRQ_W
)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // events and software access
  input wire logic [N-1:0] events,
  input wire logic status_read,
  input wire logic mask_write,
  input wire logic [N-1:0] mask_wdata,
  // state
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);

  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] mask;
    logic irq;
  } irq_state_t;

  irq_state_t state_ff;
  irq_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    // an event in the clearing read cycle survives the clear
    nxt_state.status = (status_read ? '0 : state_ff.status) | events;
    if (mask_write) begin
      nxt_state.mask = mask_wdata;
    end
    nxt_state.irq = |(nxt_state.status & nxt_state.mask);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff.status <= IRQ_STATUS_RESET[N-1:0];
      state_ff.mask <= IRQ_MASK_RESET[N-1:0];
      state_ff.irq <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign status = state_ff.status;
  assign mask = state_ff.mask;
  assign irq = state_ff.irq;

endmodule

// ---- verilog/timer2_capture_reload.sv ----
`timescale 1ns/10ps
// How it works
// - count held as high and low byte pair
// - capture/reload pair: capture target, reload source
// - counter_select clear: count every system clock
// - counter_select set: count external pin falling edges
// - capture_select set: capture on enabled trigger fall
// - capture_select clear: reload on overflow, or enabled trigger fall
// - baud select forces auto-reload, ignores capture_select
module timer2_capture_reload
  import tmr2_pkg::*;
#(
  parameter int unsigned CW = COUNT_W
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  // external pins
  input wire logic COUNT_PIN,
  input wire logic TRIGGER_PIN,
  // events out
  output logic IRQ,
  output logic BAUD_TICK
);

  typedef struct packed {
    logic [7:0] timer_control;
    logic [CW-1:0] count;
    logic [CW-1:0] capture_reload;
    logic [DATA_W-1:0] rdata;
    logic baud_tick;
  } timer_state_t;

  timer_state_t state_ff;
  timer_state_t nxt_state;

  logic count_fall;
  logic trigger_fall;
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic irq_line;
  logic status_read;
  logic mask_write;

  // control decode
  logic run_control;
  logic counter_select;
  logic capture_select;
  logic external_trigger_enable;
  logic baud_mode;
  logic auto_reload;
  logic count_step;
  logic overflow;
  logic trigger_event;
  logic overflow_flag_set;

  // bus decode
  logic wr_control;
  logic wr_reload_low;
  logic wr_reload_high;
  logic wr_count_low;
  logic wr_count_high;

  // both pins are asynchronous to CLK
  fall_edge_sync count_sync (
    .clk(CLK),
    .resetn(RESETN),
    .pin(COUNT_PIN),
    .fall(count_fall)
  );

  fall_edge_sync trigger_sync (
    .clk(CLK),
    .resetn(RESETN),
    .pin(TRIGGER_PIN),
    .fall(trigger_fall)
  );

  irq_sticky #(
    .N(IRQ_W)
  ) irq_unit (
    .clk(CLK),
    .resetn(RESETN),
    .events(irq_events),
    .status_read(status_read),
    .mask_write(mask_write),
    .mask_wdata(WDATA[IRQ_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq_line)
  );

  always_comb begin
    run_control = state_ff.timer_control[BIT_RUN_CONTROL];
    counter_select = state_ff.timer_control[BIT_COUNTER_SELECT];
    capture_select = state_ff.timer_control[BIT_CAPTURE_SELECT];
    external_trigger_enable =
      state_ff.timer_control[BIT_EXTERNAL_TRIGGER_ENABLE];
    baud_mode = state_ff.timer_control[BIT_RECEIVE_BAUD_CLOCK_SELECT] |
      state_ff.timer_control[BIT_TRANSMIT_BAUD_CLOCK_SELECT];
    auto_reload = baud_mode | ~capture_select;
    count_step = run_control & (counter_select ? count_fall : 1'b1);
    overflow = count_step & (state_ff.count == {CW{1'b1}});
    trigger_event = trigger_fall & external_trigger_enable;
    overflow_flag_set = overflow & ~baud_mode;
  end

  always_comb begin
    wr_control = WR & (ADDR == ADDR_TIMER_CONTROL);
    wr_reload_low = WR & (ADDR == ADDR_CAPTURE_RELOAD_LOW);
    wr_reload_high = WR & (ADDR == ADDR_CAPTURE_RELOAD_HIGH);
    wr_count_low = WR & (ADDR == ADDR_COUNT_LOW);
    wr_count_high = WR & (ADDR == ADDR_COUNT_HIGH);
    mask_write = WR & (ADDR == ADDR_IRQ_MASK);
    status_read = RD & (ADDR == ADDR_IRQ_STATUS);
    irq_events = '0;
    irq_events[IRQ_BIT_OVERFLOW] = overflow_flag_set;
    irq_events[IRQ_BIT_TRIGGER] = trigger_event;
    irq_events[IRQ_BIT_BAUD] = overflow & baud_mode;
  end

  always_comb begin
    nxt_state = state_ff;

    // counting, overflow first
    if (count_step) begin
      if (overflow && auto_reload) begin
        nxt_state.count = state_ff.capture_reload;
      end else begin
        nxt_state.count = state_ff.count + {{(CW-1){1'b0}}, 1'b1};
      end
    end

    // trigger pin: capture or reload, none while a baud clock
    if (trigger_event && !baud_mode) begin
      if (capture_select) begin
        nxt_state.capture_reload = state_ff.count;
      end else begin
        nxt_state.count = state_ff.capture_reload;
      end
    end

    // byte writes to the count pair win over counting
    if (wr_count_low) begin
      nxt_state.count[7:0] = WDATA;
    end
    if (wr_count_high) begin
      nxt_state.count[CW-1:8] = WDATA[CW-9:0];
    end

    // software load; a capture in the same cycle wins
    if (!(trigger_event && !baud_mode && capture_select)) begin
      if (wr_reload_low) begin
        nxt_state.capture_reload[7:0] = WDATA;
      end
      if (wr_reload_high) begin
        nxt_state.capture_reload[CW-1:8] = WDATA[CW-9:0];
      end
    end

    // control register; hardware flag sets win over a clearing write
    if (wr_control) begin
      nxt_state.timer_control = WDATA;
    end
    if (overflow_flag_set) begin
      nxt_state.timer_control[BIT_OVERFLOW_FLAG] = 1'b1;
    end
    if (trigger_event) begin
      nxt_state.timer_control[BIT_EXTERNAL_TRIGGER_FLAG] = 1'b1;
    end

    nxt_state.baud_tick = overflow & baud_mode;

    // read data, valid only in the cycle after the strobe
    nxt_state.rdata = READ_DATA_RESET;
    if (RD) begin
      unique case (ADDR)
        ADDR_TIMER_CONTROL: begin
          nxt_state.rdata = state_ff.timer_control;
        end
        ADDR_CAPTURE_RELOAD_LOW: begin
          nxt_state.rdata = state_ff.capture_reload[7:0];
        end
        ADDR_CAPTURE_RELOAD_HIGH: begin
          nxt_state.rdata = state_ff.capture_reload[CW-1:8];
        end
        ADDR_COUNT_LOW: begin
          nxt_state.rdata = state_ff.count[7:0];
        end
        ADDR_COUNT_HIGH: begin
          nxt_state.rdata = state_ff.count[CW-1:8];
        end
        ADDR_IRQ_STATUS: begin
          nxt_state.rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_status};
        end
        ADDR_IRQ_MASK: begin
          nxt_state.rdata = {{(DATA_W-IRQ_W){1'b0}}, irq_mask};
        end
        default: begin
          nxt_state.rdata = UNMAPPED_READ;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_ff.timer_control <= TIMER_CONTROL_RESET;
      state_ff.count <= COUNT_RESET[CW-1:0];
      state_ff.capture_reload <= CAPTURE_RELOAD_RESET[CW-1:0];
      state_ff.rdata <= READ_DATA_RESET;
      state_ff.baud_tick <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign RDATA = state_ff.rdata;
  assign BAUD_TICK = state_ff.baud_tick;
  assign IRQ = irq_line;

endmodule
